// ===== src/alu_pkg.sv
/*
 * shared constants and enumerations for the subtract, swap and skip datapath.
 * assumes the decoder encodes operations as op_e and that bytes are 8 bits wide.
 */
package alu_pkg;
  localparam int unsigned BYTE_W = 8;
  localparam int unsigned NIB_W = 4;
  localparam int unsigned BIT_SEL_W = 3;
  localparam logic [BYTE_W-1:0] BYTE_RST = 8'h00;
  localparam logic FLAG_RST = 1'b0;
  // cycles a taken skip occupies, dummy cycle included
  localparam int unsigned SKIP_CYCLES = 2;

  typedef enum logic [2:0] {
    OP_SKIP_BIT = 3'b000,
    OP_SUB_ACC = 3'b001,
    OP_SUB_MEM = 3'b010,
    OP_SUB_IMM = 3'b011,
    OP_NIB_SWAP = 3'b100
  } op_e;

  typedef enum logic {
    ST_IDLE = 1'b0,
    ST_DUMMY = 1'b1
  } state_e;
endpackage : alu_pkg

// ===== src/sub_flags_unit.sv
/*
 * combinational byte subtractor with status flag generation.
 * assumes its caller registers the results; no clock here.
 */
`timescale 1ns/10ps
module sub_flags_unit
  import alu_pkg::*;
(
  input wire logic [BYTE_W-1:0] minuend_i,
  input wire logic [BYTE_W-1:0] subtrahend_i,
  output logic [BYTE_W-1:0] diff_o,
  output logic carry_o,
  output logic half_o,
  output logic ov_o,
  output logic zero_o
);
  logic [BYTE_W:0] wide;

  always_comb begin
    wide = {1'b0, minuend_i} - {1'b0, subtrahend_i};
    diff_o = wide[BYTE_W-1:0];
    carry_o = ~wide[BYTE_W];
    half_o = (minuend_i[NIB_W-1:0] >= subtrahend_i[NIB_W-1:0]);
    ov_o = (minuend_i[BYTE_W-1] ^ subtrahend_i[BYTE_W-1]) &
           (minuend_i[BYTE_W-1] ^ wide[BYTE_W-1]);
    zero_o = (wide[BYTE_W-1:0] == BYTE_RST);
  end
endmodule : sub_flags_unit

// ===== src/subtract_swap_skip_alu.sv
/*
 * execution datapath for bit-test skip, three subtract forms and nibble swap.
 * assumes the sequencer supplies work_register and the addressed memory byte in the
 * request cycle and applies the registered write strobes one cycle later.
 */
`timescale 1ns/10ps
// Notes on behaviour
// - skip op tests selected memory bit; a one suppresses the next instruction.
// - a taken skip adds a dummy cycle, two cycles in total.
// - bit zero continues normally; skip op never touches status flags.
// - memory subtract into work_register: work_register minus memory byte.
// - every subtract sets carry as not-borrow and updates all four flags.
// - minus_to_memory writes the difference to memory, work_register kept.
// - immediate subtract: work_register minus instruction constant into work_register.
// - nibble_exchange swaps the two nibbles of the memory byte in place.
// - nibble_exchange changes no flag and leaves work_register alone.
module subtract_swap_skip_alu
  import alu_pkg::*;
(
  input wire logic mclk_i,
  input wire logic nrst_i,
  input wire logic ce_i,
  input wire logic start_i,
  input wire logic [2:0] op_i,
  input wire logic [BIT_SEL_W-1:0] bit_sel_i,
  input wire logic [BYTE_W-1:0] acc_i,
  input wire logic [BYTE_W-1:0] mem_i,
  input wire logic [BYTE_W-1:0] imm_i,
  output logic busy_o,
  output logic done_o,
  output logic skip_o,
  output logic acc_we_o,
  output logic [BYTE_W-1:0] acc_data_o,
  output logic mem_we_o,
  output logic [BYTE_W-1:0] mem_data_o,
  output logic flags_we_o,
  output logic carry_o,
  output logic zero_o,
  output logic ov_o,
  output logic half_o
);
  state_e state, next_state;
  logic next_busy, next_done, next_skip, next_acc_we, next_mem_we, next_flags_we;
  logic [BYTE_W-1:0] next_acc_data, next_mem_data;
  logic next_carry, next_zero, next_ov, next_half;
  logic [BYTE_W-1:0] operand_b, diff;
  logic u_carry, u_half, u_ov, u_zero;
  logic take;

  assign take = start_i && (state == ST_IDLE);
  assign operand_b = (op_e'(op_i) == OP_SUB_IMM) ? imm_i : mem_i;

  sub_flags_unit u_sub (
    .minuend_i(acc_i),
    .subtrahend_i(operand_b),
    .diff_o(diff),
    .carry_o(u_carry),
    .half_o(u_half),
    .ov_o(u_ov),
    .zero_o(u_zero)
  );

  always_comb begin
    next_state = state;
    next_busy = 1'b0;
    next_done = 1'b0;
    next_skip = 1'b0;
    next_acc_we = 1'b0;
    next_mem_we = 1'b0;
    next_flags_we = 1'b0;
    next_acc_data = acc_data_o;
    next_mem_data = mem_data_o;
    next_carry = carry_o;
    next_zero = zero_o;
    next_ov = ov_o;
    next_half = half_o;
    if (state == ST_DUMMY) begin
      next_state = ST_IDLE;
      next_done = 1'b1;
    end else if (take) begin
      next_done = 1'b1;
      unique case (op_e'(op_i))
        OP_SKIP_BIT: begin
          if (mem_i[bit_sel_i]) begin
            next_state = ST_DUMMY;
            next_busy = 1'b1;
            next_skip = 1'b1;
            next_done = 1'b0;
          end
        end
        OP_SUB_ACC, OP_SUB_IMM: begin
          next_acc_we = 1'b1;
          next_acc_data = diff;
        end
        OP_SUB_MEM: begin
          next_mem_we = 1'b1;
          next_mem_data = diff;
        end
        OP_NIB_SWAP: begin
          next_mem_we = 1'b1;
          next_mem_data = {mem_i[NIB_W-1:0], mem_i[BYTE_W-1:NIB_W]};
        end
        default: begin
        end
      endcase
      if (op_e'(op_i) inside {OP_SUB_ACC, OP_SUB_MEM, OP_SUB_IMM}) begin
        next_flags_we = 1'b1;
        next_carry = u_carry;
        next_zero = u_zero;
        next_ov = u_ov;
        next_half = u_half;
      end
    end
  end

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state <= ST_IDLE;
      busy_o <= 1'b0;
      done_o <= 1'b0;
      skip_o <= 1'b0;
      acc_we_o <= 1'b0;
      mem_we_o <= 1'b0;
      flags_we_o <= 1'b0;
      acc_data_o <= BYTE_RST;
      mem_data_o <= BYTE_RST;
      carry_o <= FLAG_RST;
      zero_o <= FLAG_RST;
      ov_o <= FLAG_RST;
      half_o <= FLAG_RST;
    end else if (ce_i) begin
      state <= next_state;
      busy_o <= next_busy;
      done_o <= next_done;
      skip_o <= next_skip;
      acc_we_o <= next_acc_we;
      mem_we_o <= next_mem_we;
      flags_we_o <= next_flags_we;
      acc_data_o <= next_acc_data;
      mem_data_o <= next_mem_data;
      carry_o <= next_carry;
      zero_o <= next_zero;
      ov_o <= next_ov;
      half_o <= next_half;
    end
  end

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!nrst_i);

  logic req_ok;
  assign req_ok = ce_i && take;

  // sign-extended difference, wraps when the two top bits differ
  logic signed [BYTE_W:0] sdiff;
  assign sdiff = $signed({acc_i[BYTE_W-1], acc_i}) - $signed({operand_b[BYTE_W-1], operand_b});

  skip_taken_a: assert property (
    req_ok && op_e'(op_i) == OP_SKIP_BIT && mem_i[bit_sel_i] |=> skip_o && busy_o && !done_o
  ) else $error("taken skip not flagged");

  skip_dummy_a: assert property (
    skip_o && ce_i |=> done_o && !busy_o && !skip_o
  ) else $error("dummy cycle missing after skip");

  skip_clear_a: assert property (
    req_ok && op_e'(op_i) == OP_SKIP_BIT && !mem_i[bit_sel_i] |=> done_o && !skip_o && !flags_we_o
  ) else $error("skip on clear bit or flags touched");

  sub_acc_a: assert property (
    req_ok && op_e'(op_i) == OP_SUB_ACC |=>
      acc_we_o && !mem_we_o && acc_data_o == 8'($past(acc_i) - $past(mem_i))
  ) else $error("acc minus mem wrong");

  carry_inv_a: assert property (
    req_ok && op_e'(op_i) inside {OP_SUB_ACC, OP_SUB_MEM, OP_SUB_IMM} |=>
      flags_we_o && carry_o == ($past(acc_i) >= $past(operand_b))
  ) else $error("carry not inverse borrow");

  flag_calc_a: assert property (
    req_ok && op_e'(op_i) inside {OP_SUB_ACC, OP_SUB_MEM, OP_SUB_IMM} |=>
      zero_o == ($past(acc_i) == $past(operand_b)) &&
      half_o == ($past(acc_i[3:0]) >= $past(operand_b[3:0]))
  ) else $error("zero or half flag wrong");

  sub_mem_a: assert property (
    req_ok && op_e'(op_i) == OP_SUB_MEM |=>
      mem_we_o && !acc_we_o && mem_data_o == 8'($past(acc_i) - $past(mem_i))
  ) else $error("minus_to_memory wrong");

  sub_imm_a: assert property (
    req_ok && op_e'(op_i) == OP_SUB_IMM |=> acc_we_o && acc_data_o == 8'($past(acc_i) - $past(imm_i))
  ) else $error("immediate subtract wrong");

  nib_swap_a: assert property (
    req_ok && op_e'(op_i) == OP_NIB_SWAP |=> mem_we_o && mem_data_o == {$past(mem_i[3:0]), $past(mem_i[7:4])}
  ) else $error("nibble swap wrong");

  swap_quiet_a: assert property (
    req_ok && op_e'(op_i) == OP_NIB_SWAP |=> !flags_we_o && !acc_we_o && $stable(carry_o) && $stable(zero_o)
  ) else $error("swap touched flags or acc");

  ov_flag_a: assert property (
    req_ok && op_e'(op_i) inside {OP_SUB_ACC, OP_SUB_MEM, OP_SUB_IMM} |=>
      ov_o == $past(sdiff[BYTE_W] ^ sdiff[BYTE_W-1])
  ) else $error("signed wrap flag wrong");

  busy_refuse_a: assert property (
    busy_o && ce_i |=> !acc_we_o && !mem_we_o && !flags_we_o && !skip_o
  ) else $error("request taken during dummy cycle");

  flags_hold_a: assert property (
    !flags_we_o |-> $stable(carry_o) && $stable(zero_o) && $stable(ov_o) && $stable(half_o)
  ) else $error("flags moved without a flag write");

  ce_hold_a: assert property (
    !ce_i |=> $stable(done_o) && $stable(busy_o) && $stable(acc_we_o) && $stable(mem_we_o) && $stable(flags_we_o)
  ) else $error("outputs moved with clock enable low");

  odd_op_a: assert property (
    req_ok && op_i > 3'h4 |=> done_o && !acc_we_o && !mem_we_o && !flags_we_o && !skip_o
  ) else $error("unused opcode wrote something");

  skip_seen_c: cover property (req_ok && op_e'(op_i) == OP_SKIP_BIT && mem_i[bit_sel_i] ##1 skip_o ##1 done_o);
  borrow_seen_c: cover property (req_ok && op_e'(op_i) == OP_SUB_MEM ##1 !carry_o);
  wrap_seen_c: cover property (req_ok && op_e'(op_i) == OP_SUB_ACC ##1 ov_o);
  swap_seen_c: cover property (req_ok && op_e'(op_i) == OP_NIB_SWAP ##1 mem_we_o);
  refuse_seen_c: cover property (busy_o && start_i && ce_i ##1 done_o);
endmodule : subtract_swap_skip_alu

// ===== verification/seq_mem_model.sv
/*
 * work register and one addressed data memory byte, as the sequencer keeps them.
 * assumes write strobes from the datapath land at the next rising edge.
 */
`timescale 1ns/10ps
module seq_mem_model
  import alu_pkg::*;
(
  input wire logic mclk_i,
  input wire logic nrst_i,
  input wire logic ld_i,
  input wire logic [BYTE_W-1:0] ld_acc_i,
  input wire logic [BYTE_W-1:0] ld_mem_i,
  input wire logic acc_we_i,
  input wire logic [BYTE_W-1:0] acc_data_i,
  input wire logic mem_we_i,
  input wire logic [BYTE_W-1:0] mem_data_i,
  output logic [BYTE_W-1:0] acc_o,
  output logic [BYTE_W-1:0] mem_o
);
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      acc_o <= BYTE_RST;
      mem_o <= BYTE_RST;
    end else if (ld_i) begin
      acc_o <= ld_acc_i;
      mem_o <= ld_mem_i;
    end else begin
      if (acc_we_i) acc_o <= acc_data_i;
      if (mem_we_i) mem_o <= mem_data_i;
    end
  end
endmodule : seq_mem_model

// ===== verification/subtract_swap_skip_alu_test.sv
/*
 * self-checking bench for the subtract, swap and skip datapath.
 * assumes the memory model holds the operands; clock enable high except in the freeze scenario.
 */
`timescale 1ns/10ps
module subtract_swap_skip_alu_test import alu_pkg::*;;
  logic mclk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic start = 1'b0;
  logic ld = 1'b0;
  logic ce = 1'b1;
  logic [2:0] op = 3'h0;
  logic [2:0] bsel = 3'h0;
  logic [7:0] ld_acc = 8'h00, ld_mem = 8'h00, imm = 8'h00, acc, mem, acc_d, mem_d;
  logic busy, done, skip, acc_we, mem_we, flags_we, carry, zero, ov, half;
  int n_errors = 0;
  int comparisons = 0;
  int cycles = 0;
  always #2.5 mclk_i = ~mclk_i;
  subtract_swap_skip_alu u_dut (.mclk_i(mclk_i), .nrst_i(nrst_i), .ce_i(ce), .start_i(start), .op_i(op),
    .bit_sel_i(bsel), .acc_i(acc), .mem_i(mem), .imm_i(imm), .busy_o(busy), .done_o(done), .skip_o(skip),
    .acc_we_o(acc_we), .acc_data_o(acc_d), .mem_we_o(mem_we), .mem_data_o(mem_d), .flags_we_o(flags_we),
    .carry_o(carry), .zero_o(zero), .ov_o(ov), .half_o(half));
  seq_mem_model u_mem (.mclk_i(mclk_i), .nrst_i(nrst_i), .ld_i(ld), .ld_acc_i(ld_acc), .ld_mem_i(ld_mem),
    .acc_we_i(acc_we), .acc_data_i(acc_d), .mem_we_i(mem_we), .mem_data_i(mem_d), .acc_o(acc), .mem_o(mem));
  task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t: byte %h expected %h", $time, got, exp);
    end
  endtask : check_byte
  task automatic check_bit(input logic got, input logic exp);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t: flag %b expected %b", $time, got, exp);
    end
  endtask : check_bit
  // preload operands, then one request; returns settled in the answer cycle
  task automatic issue(input logic [2:0] o, input logic [2:0] b, input logic [7:0] a, m, x);
    @(posedge mclk_i);
    ld <= 1'b1;
    ld_acc <= a;
    ld_mem <= m;
    @(posedge mclk_i);
    ld <= 1'b0;
    start <= 1'b1;
    op <= o;
    bsel <= b;
    imm <= x;
    @(posedge mclk_i);
    start <= 1'b0;
    #1;
  endtask : issue
  task automatic sub_case(input logic [2:0] o, input logic [7:0] a, m, x);
    logic [7:0] b;
    logic [7:0] d;
    b = (o == OP_SUB_IMM) ? x : m;
    d = a - b;
    issue(o, 3'h0, a, m, x);
    check_bit(done, 1'b1);
    check_bit(flags_we, 1'b1);
    check_bit(carry, a >= b);
    check_bit(zero, d == 8'h00);
    check_bit(half, a[3:0] >= b[3:0]);
    check_bit(ov, (a[7] != b[7]) && (d[7] != a[7]));
    @(posedge mclk_i);
    #1;
    check_byte(acc, (o == OP_SUB_MEM) ? a : d);
    check_byte(mem, (o == OP_SUB_MEM) ? d : m);
  endtask : sub_case
  task automatic skip_case(input logic [2:0] b, input logic [7:0] m);
    logic [3:0] f;
    f = {carry, zero, ov, half};
    issue(OP_SKIP_BIT, b, 8'h3c, m, 8'h00);
    check_bit(skip, m[b]);
    check_bit(busy, m[b]);
    check_bit(done, !m[b]);
    check_bit(flags_we, 1'b0);
    @(posedge mclk_i);
    #1;
    check_bit(done, m[b]);
    check_bit(skip, 1'b0);
    check_byte({4'h0, carry, zero, ov, half}, {4'h0, f});
  endtask : skip_case
  task automatic swap_case(input logic [7:0] a, m);
    logic [3:0] f;
    f = {carry, zero, ov, half};
    issue(OP_NIB_SWAP, 3'h0, a, m, 8'h00);
    check_bit(acc_we, 1'b0);
    check_bit(flags_we, 1'b0);
    @(posedge mclk_i);
    #1;
    check_byte(mem, {m[3:0], m[7:4]});
    check_byte(acc, a);
    check_byte({4'h0, carry, zero, ov, half}, {4'h0, f});
  endtask : swap_case
  // reset in mid-run clears every output
  task automatic reset_case;
    @(posedge mclk_i);
    nrst_i <= 1'b0;
    repeat (2) @(posedge mclk_i);
    #1;
    check_byte({carry, zero, ov, half, done, busy, skip, flags_we}, 8'h00);
    check_byte({acc_we, mem_we, 6'h00}, 8'h00);
    check_byte(acc_d, 8'h00);
    check_byte(mem_d, 8'h00);
    @(posedge mclk_i);
    nrst_i <= 1'b1;
  endtask : reset_case
  // clock enable low after a take: pulses hold, a waiting request is not taken
  task automatic freeze_case(input logic [7:0] a, m);
    @(posedge mclk_i);
    ld <= 1'b1;
    ld_acc <= a;
    ld_mem <= m;
    @(posedge mclk_i);
    ld <= 1'b0;
    start <= 1'b1;
    op <= OP_SUB_ACC;
    @(posedge mclk_i);
    ce <= 1'b0;
    op <= OP_NIB_SWAP;
    repeat (2) @(posedge mclk_i);
    #1;
    check_bit(done, 1'b1);
    check_bit(acc_we, 1'b1);
    check_bit(mem_we, 1'b0);
    @(posedge mclk_i);
    ce <= 1'b1;
    start <= 1'b0;
    @(posedge mclk_i);
    #1;
    check_bit(done, 1'b0);
    check_bit(acc_we, 1'b0);
    check_byte(acc, 8'(a - m));
    check_byte(mem, m);
    check_bit(carry, a >= m);
  endtask : freeze_case
  // subtract then swap on consecutive edges
  task automatic pair_case(input logic [7:0] a, m);
    @(posedge mclk_i);
    ld <= 1'b1;
    ld_acc <= a;
    ld_mem <= m;
    @(posedge mclk_i);
    ld <= 1'b0;
    start <= 1'b1;
    op <= OP_SUB_ACC;
    @(posedge mclk_i);
    op <= OP_NIB_SWAP;
    @(posedge mclk_i);
    start <= 1'b0;
    #1;
    check_bit(done, 1'b1);
    check_bit(mem_we, 1'b1);
    check_bit(acc_we, 1'b0);
    check_bit(flags_we, 1'b0);
    @(posedge mclk_i);
    #1;
    check_byte(mem, {m[3:0], m[7:4]});
    check_byte(acc, 8'(a - m));
    check_bit(carry, a >= m);
  endtask : pair_case
  // taken skip with a subtract waiting through the dummy cycle
  task automatic refuse_case(input logic [7:0] a, m);
    @(posedge mclk_i);
    ld <= 1'b1;
    ld_acc <= a;
    ld_mem <= m;
    @(posedge mclk_i);
    ld <= 1'b0;
    start <= 1'b1;
    op <= OP_SKIP_BIT;
    bsel <= 3'h0;
    @(posedge mclk_i);
    op <= OP_SUB_ACC;
    @(posedge mclk_i);
    start <= 1'b0;
    #1;
    check_bit(done, 1'b1);
    check_bit(acc_we, 1'b0);
    check_bit(flags_we, 1'b0);
    @(posedge mclk_i);
    #1;
    check_bit(done, 1'b0);
    check_byte(acc, a);
  endtask : refuse_case
  // unused opcode: done pulse only
  task automatic odd_case(input logic [7:0] a, m);
    issue(3'h7, 3'h0, a, m, 8'h00);
    check_bit(done, 1'b1);
    check_bit(acc_we, 1'b0);
    check_bit(mem_we, 1'b0);
    check_bit(flags_we, 1'b0);
    @(posedge mclk_i);
    #1;
    check_byte(acc, a);
    check_byte(mem, m);
  endtask : odd_case
  task automatic tally_and_finish;
    $display("comparisons %0d errors %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : tally_and_finish
  always @(posedge mclk_i) begin
    cycles++;
    if (cycles == 3000) begin
      n_errors++;
      tally_and_finish();
    end
  end
  initial begin
    repeat (16) @(posedge mclk_i);
    nrst_i <= 1'b1;
    for (int o = 1; o <= 3; o++) begin
      sub_case(3'(o), 8'h05, 8'h03, 8'h04);
      sub_case(3'(o), 8'h03, 8'h05, 8'h07);
      sub_case(3'(o), 8'h80, 8'h01, 8'h01);
      sub_case(3'(o), 8'h10, 8'h01, 8'h7f);
      sub_case(3'(o), 8'h42, 8'h42, 8'h42);
    end
    reset_case();
    freeze_case(8'h09, 8'h04);
    pair_case(8'h20, 8'h31);
    for (int i = 0; i < 8; i++) begin
      skip_case(3'(i), 8'h01 << i);
      skip_case(3'(i), ~(8'h01 << i));
    end
    swap_case(8'h5a, 8'ha5);
    swap_case(8'h00, 8'h1e);
    refuse_case(8'h3c, 8'h81);
    odd_case(8'h11, 8'h22);
    tally_and_finish();
  end
endmodule : subtract_swap_skip_alu_test
